// ===== rtl/tai_pkg.sv
// Contract
// - Extended superframe bit set selects extended superframe; clear lets mode pair choose.
// - Alternate T1DM: RED handled as standard formats, YELLOW still by T1DM rules.
// - Extended superframe: mode 00 means 4 kbit link, 01 or 10 mean 2 kbit.
// - Fast deassert on: RED drops within 120 ms of going in frame.
// - Fast deassert on: AIS drops within 180 ms of in frame or clean interval.
// - Fast deassert off: normal RED and AIS deassertion timing applies.
// - Each alarm enable bit independently lets its alarm changes raise an interrupt.
// - Reset clears all alarm interrupt enable bits.
// - Change flags in bits 5..3 set when an enabled alarm change occurs.
// - Status bits 2..0 show live YELLOW, RED and AIS states.
// - Status read clears the change flags and the interrupt, live bits untouched.
// - AIS present when out of frame whole 60 ms and at most 126 zeros.
// - ESF YELLOW needs 8 clean codes per 40 ms at 4 kbit, 4 at 2 kbit.
package tai_pkg;
	// Register indices; byte address is four times the index
	localparam logic [5:0] TAI_IDX_CFG  = 6'h2C;
	localparam logic [5:0] TAI_IDX_IEN  = 6'h2D;
	localparam logic [5:0] TAI_IDX_STAT = 6'h2E;
	// Field positions
	localparam int TAI_CFG_ESF    = 4;
	localparam int TAI_CFG_FMS_HI = 3;
	localparam int TAI_CFG_FMS_LO = 2;
	localparam int TAI_IEN_FAST   = 4;
	localparam int TAI_IEN_TEST_SPEEDUP  = 3;
	localparam int TAI_STAT_FLAG  = 3;
	// Alarm positions, shared by enables, flags and live bits
	localparam int TAI_ALM_AIS = 0;
	localparam int TAI_ALM_RED = 1;
	localparam int TAI_ALM_YEL = 2;
	// Reset values
	localparam logic [2:0] TAI_CFG_RST = 3'h0;
	localparam logic [4:0] TAI_IEN_RST = 5'h00;
	// Mode pair codes
	localparam logic [1:0] TAI_FMS_SF   = 2'h0;
	localparam logic [1:0] TAI_FMS_T1DM = 2'h1;
	localparam logic [1:0] TAI_FMS_LOOP = 2'h2;
	localparam logic [1:0] TAI_FMS_ALT  = 2'h3;
	// Timing
	localparam int TAI_CLK_KHZ    = 250000;
	localparam int TAI_WIN_RED_MS = 40;
	localparam int TAI_WIN_AIS_MS = 60;
	localparam int TAI_WIN_W      = 24;
	// Thresholds per interval
	localparam logic [3:0] TAI_YEL_ESF4_MIN = 4'h8;
	localparam logic [3:0] TAI_YEL_ESF2_MIN = 4'h4;
	localparam logic [4:0] TAI_YEL_SF_MAX   = 5'h10;
	localparam logic [4:0] TAI_YEL_T1DM_MAX = 5'h04;
	localparam logic [6:0] TAI_AIS_ONES_MAX = 7'h7E;
	// Fast deassert: two clean intervals fit inside 120 ms and 180 ms
	localparam logic [3:0] TAI_RED_FAST_CLR = 4'h2;
	localparam logic [3:0] TAI_AIS_FAST_CLR = 4'h2;
	// Alarm integrator states
	typedef enum logic {TAI_ABSENT, TAI_PRESENT} tai_alm_state_t;
endpackage

// ===== rtl/tai_alarm_fsm.sv
`timescale 1ns/1ps
`default_nettype none
module tai_alarm_fsm
	import tai_pkg::*;
(
	// Clock and reset
	input  wire logic       i_clk_sys,
	input  wire logic       i_rst_n,
	// Interval verdicts
	input  wire logic       i_end,
	input  wire logic       i_present,
	input  wire logic [3:0] i_set_need,
	input  wire logic [3:0] i_clr_need,
	// Alarm state
	output logic            o_state
);
	tai_alm_state_t state_q;
	tai_alm_state_t state_d;
	logic [3:0]     run_q;
	logic [3:0]     run_d;
	logic [3:0]     run_inc;
	logic           against;

	// Interval outcome that argues for the opposite state
	assign run_inc = run_q + 4'h1;
	assign against = (state_q == TAI_ABSENT) ? i_present : !i_present;

	// Consecutive opposing intervals flip the alarm
	always_comb
	begin
		state_d = state_q;
		run_d   = run_q;
		if (i_end)
		begin
			run_d = 4'h0;
			if (against)
			begin
				case (state_q)
					TAI_ABSENT:
					begin
						if (run_inc >= i_set_need)
							state_d = TAI_PRESENT;
						else
							run_d = run_inc;
					end
					TAI_PRESENT:
					begin
						if (run_inc >= i_clr_need)
							state_d = TAI_ABSENT;
						else
							run_d = run_inc;
					end
					default: state_d = TAI_ABSENT;
				endcase
			end
		end
	end

	// State registers
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			state_q <= TAI_ABSENT;
			run_q   <= 4'h0;
		end
		else
		begin
			state_q <= state_d;
			run_q   <= run_d;
		end
	end

	assign o_state = (state_q == TAI_PRESENT);
endmodule
`default_nettype wire

// ===== rtl/tai_alarm_integrator.sv
`timescale 1ns/1ps
`default_nettype none
module tai_alarm_integrator
	import tai_pkg::*;
#(
	parameter int P_WIN_RED_CYC = TAI_WIN_RED_MS * TAI_CLK_KHZ,
	parameter int P_WIN_AIS_CYC = TAI_WIN_AIS_MS * TAI_CLK_KHZ,
	parameter int P_TEST_SPEEDUP_DIV   = 1000,
	parameter logic [3:0] P_RED_SET      = 4'h1,
	parameter logic [3:0] P_RED_SET_T1DM = 4'h2,
	parameter logic [3:0] P_RED_CLR      = 4'h8,
	parameter logic [3:0] P_YEL_SET      = 4'h1,
	parameter logic [3:0] P_YEL_CLR      = 4'h1,
	parameter logic [3:0] P_AIS_SET      = 4'h1,
	parameter logic [3:0] P_AIS_CLR      = 4'h6
)
(
	// Clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst_n,
	// Avalon-MM slave
	input  wire logic [7:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [3:0]  i_avs_byteenable,
	output logic      [31:0] o_avs_readdata,
	output logic             o_avs_waitrequest,
	// Framer indications
	input  wire logic        i_in_frame,
	input  wire logic        i_pcm_valid,
	input  wire logic        i_pcm_bit,
	input  wire logic        i_bit2_valid,
	input  wire logic        i_bit2,
	input  wire logic        i_ybit_valid,
	input  wire logic        i_ybit,
	input  wire logic        i_yel_code_ok,
	// Alarm states and interrupt
	output logic             o_yellow_state,
	output logic             o_red_state,
	output logic             o_ais_state,
	output logic             o_irq_out_n
);
	logic [2:0]           cfg_q;
	logic [4:0]           ien_q;
	logic [2:0]           flag_q;
	logic [2:0]           flag_d;
	logic [2:0]           live;
	logic [2:0]           live_prev_q;
	logic                 ack_q;
	logic [31:0]          rdata_q;
	logic [TAI_WIN_W-1:0] cnt_red_q;
	logic [TAI_WIN_W-1:0] cnt_ais_q;
	logic                 oof_seen_q;
	logic                 oof_all_q;
	logic [3:0]           codes_q;
	logic [4:0]           yel_ones_q;
	logic [6:0]           ais_ones_q;

	// Mode decode from the configuration and interrupt enable registers
	wire       esf    = cfg_q[TAI_CFG_ESF-2];
	wire [1:0] fms    = cfg_q[TAI_CFG_FMS_HI-2:TAI_CFG_FMS_LO-2];
	wire       esf4   = esf && (fms == TAI_FMS_SF);
	wire       esf2   = esf && (fms == TAI_FMS_T1DM || fms == TAI_FMS_LOOP);
	wire       t1dm_y = !esf && (fms == TAI_FMS_T1DM || fms == TAI_FMS_ALT);
	wire       t1dm_r = !esf && (fms == TAI_FMS_T1DM);
	wire       sf_y   = !esf && (fms == TAI_FMS_SF || fms == TAI_FMS_LOOP);
	wire       fast   = ien_q[TAI_IEN_FAST];
	wire       test_speedup  = ien_q[TAI_IEN_TEST_SPEEDUP];

	// Interval lengths; test speedup shortens both windows
	wire [TAI_WIN_W-1:0] last_red = test_speedup
		? TAI_WIN_W'(P_WIN_RED_CYC / P_TEST_SPEEDUP_DIV - 1)
		: TAI_WIN_W'(P_WIN_RED_CYC - 1);
	wire [TAI_WIN_W-1:0] last_ais = test_speedup
		? TAI_WIN_W'(P_WIN_AIS_CYC / P_TEST_SPEEDUP_DIV - 1)
		: TAI_WIN_W'(P_WIN_AIS_CYC - 1);
	wire end_red = (cnt_red_q == last_red);
	wire end_ais = (cnt_ais_q == last_ais);

	// Yellow samples come from bit 2 or the Y bit by format
	wire yel_smp_v = sf_y ? i_bit2_valid : (t1dm_y && i_ybit_valid);
	wire yel_smp   = sf_y ? i_bit2 : i_ybit;

	// Per-interval verdicts
	wire red_pres = oof_seen_q || !i_in_frame;
	wire yel_pres = esf4 ? (codes_q >= TAI_YEL_ESF4_MIN)
		: esf2 ? (codes_q >= TAI_YEL_ESF2_MIN)
		: sf_y ? (yel_ones_q <= TAI_YEL_SF_MAX)
		: t1dm_y && (yel_ones_q <= TAI_YEL_T1DM_MAX);
	wire ais_pres = oof_all_q && !i_in_frame
		&& (ais_ones_q <= TAI_AIS_ONES_MAX);

	// Saturating counter step
	function automatic logic [6:0] sat_inc(input logic [6:0] v,
		input logic [6:0] lim);
		sat_inc = (v >= lim) ? v : v + 7'h01;
	endfunction

	// Next counts; a call result cannot be part-selected directly
	wire [6:0] codes_inc = sat_inc({3'h0, codes_q}, 7'h0F);
	wire [6:0] yel_inc   = sat_inc({2'h0, yel_ones_q}, 7'h1F);

	// Window timers free-run and wrap at their interval end
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			cnt_red_q <= '0;
			cnt_ais_q <= '0;
		end
		else
		begin
			cnt_red_q <= end_red ? '0 : cnt_red_q + 1'b1;
			cnt_ais_q <= end_ais ? '0 : cnt_ais_q + 1'b1;
		end
	end

	// Forty millisecond accumulators; code and yellow samples in the end cycle are dropped
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			oof_seen_q <= 1'b0;
			codes_q    <= 4'h0;
			yel_ones_q <= 5'h00;
		end
		else if (end_red)
		begin
			oof_seen_q <= 1'b0;
			codes_q    <= 4'h0;
			yel_ones_q <= 5'h00;
		end
		else
		begin
			oof_seen_q <= red_pres;
			if (i_yel_code_ok)
				codes_q <= codes_inc[3:0];
			if (yel_smp_v && yel_smp)
				yel_ones_q <= yel_inc[4:0];
		end
	end

	// Sixty millisecond accumulators for AIS
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			oof_all_q  <= 1'b1;
			ais_ones_q <= 7'h00;
		end
		else if (end_ais)
		begin
			oof_all_q  <= 1'b1;
			ais_ones_q <= 7'h00;
		end
		else
		begin
			oof_all_q <= oof_all_q && !i_in_frame;
			// AIS is all ones, so zeros are what disqualify it
			if (i_pcm_valid && !i_pcm_bit)
				ais_ones_q <= sat_inc(ais_ones_q, 7'h7F);
		end
	end

	// Per-alarm integrator inputs, indexed by alarm position
	logic [2:0] win_end;
	logic [2:0] present;
	logic [3:0] set_need [3];
	logic [3:0] clr_need [3];

	assign win_end[TAI_ALM_YEL]  = end_red;
	assign win_end[TAI_ALM_RED]  = end_red;
	assign win_end[TAI_ALM_AIS]  = end_ais;
	assign present[TAI_ALM_YEL]  = yel_pres;
	assign present[TAI_ALM_RED]  = red_pres;
	assign present[TAI_ALM_AIS]  = ais_pres;
	assign set_need[TAI_ALM_YEL] = P_YEL_SET;
	assign set_need[TAI_ALM_RED] = t1dm_r ? P_RED_SET_T1DM : P_RED_SET;
	assign set_need[TAI_ALM_AIS] = P_AIS_SET;
	assign clr_need[TAI_ALM_YEL] = P_YEL_CLR;
	assign clr_need[TAI_ALM_RED] = fast ? TAI_RED_FAST_CLR : P_RED_CLR;
	assign clr_need[TAI_ALM_AIS] = fast ? TAI_AIS_FAST_CLR : P_AIS_CLR;

	// One integrator per alarm
	genvar g;
	generate
		for (g = 0; g < 3; g++)
		begin : g_alm
			tai_alarm_fsm u_fsm (
				.i_clk_sys  (i_clk_sys),
				.i_rst_n    (i_rst_n),
				.i_end      (win_end[g]),
				.i_present  (present[g]),
				.i_set_need (set_need[g]),
				.i_clr_need (clr_need[g]),
				.o_state    (live[g])
			);
		end
	endgenerate

	// Bus decode; one wait cycle per access gives a registered read word
	wire        req      = i_avs_read || i_avs_write;
	wire        take     = req && ack_q;
	wire [5:0]  idx      = i_avs_address[7:2];
	wire        wr_lane  = i_avs_write && take && i_avs_byteenable[0];
	wire        wr_cfg   = wr_lane && (idx == TAI_IDX_CFG);
	wire        wr_ien   = wr_lane && (idx == TAI_IDX_IEN);
	wire        wr_stat  = wr_lane && (idx == TAI_IDX_STAT);
	wire        rd_stat  = i_avs_read && take && (idx == TAI_IDX_STAT);
	wire [7:0]  stat_b   = {2'h0, flag_q, live};
	wire [7:0]  rd_byte  = (idx == TAI_IDX_CFG)  ? {3'h0, cfg_q, 2'h0}
		: (idx == TAI_IDX_IEN)  ? {3'h0, ien_q}
		: (idx == TAI_IDX_STAT) ? stat_b
		: 8'h00;
	assign o_avs_waitrequest = req && !ack_q;

	// Clear only flags the reader saw; a fresh change wins over the clear
	wire [2:0] clr_rd  = rd_stat ? rdata_q[TAI_STAT_FLAG+:3] : 3'h0;
	wire [2:0] clr_wr  = wr_stat ? i_avs_writedata[TAI_STAT_FLAG+:3] : 3'h0;
	wire [2:0] chg     = live ^ live_prev_q;
	wire [2:0] raise   = chg & ien_q[2:0];
	assign flag_d = (flag_q & ~(clr_rd | clr_wr)) | raise;

	// Bus handshake and read capture
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			ack_q   <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end
		else
		begin
			ack_q <= req && !ack_q;
			if (req && !ack_q)
				rdata_q <= {24'h00_0000, rd_byte};
		end
	end

	// Software registers
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			cfg_q <= TAI_CFG_RST;
			ien_q <= TAI_IEN_RST;
		end
		else
		begin
			if (wr_cfg)
				cfg_q <= i_avs_writedata[TAI_CFG_ESF:TAI_CFG_FMS_LO];
			if (wr_ien)
				ien_q <= i_avs_writedata[TAI_IEN_FAST:0];
		end
	end

	// Change flags and edge reference
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			flag_q      <= 3'h0;
			live_prev_q <= 3'h0;
		end
		else
		begin
			flag_q      <= flag_d;
			live_prev_q <= live;
		end
	end

	// Outputs
	assign o_avs_readdata = rdata_q;
	assign o_irq_out_n    = !(|(flag_q & ien_q[2:0]));
	assign o_yellow_state = live[TAI_ALM_YEL];
	assign o_red_state    = live[TAI_ALM_RED];
	assign o_ais_state    = live[TAI_ALM_AIS];
endmodule
`default_nettype wire

// ===== tb/tai_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module tai_monitor
	import tai_pkg::*;
(
	// Clock, reset and bus
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst_n,
	input  wire logic [7:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] o_avs_readdata,
	input  wire logic        o_avs_waitrequest,
	// Line and alarms
	input  wire logic        i_in_frame,
	input  wire logic        o_yellow_state,
	input  wire logic        o_red_state,
	input  wire logic        o_ais_state,
	input  wire logic        o_irq_out_n
);
	// Accepted access and its register
	wire       take = (i_avs_read | i_avs_write) & !o_avs_waitrequest;
	wire [5:0] idx  = i_avs_address[7:2];
	wire [2:0] alm  = {o_yellow_state, o_red_state, o_ais_state};
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	// Bus handshake
	chk_wait_first: assert property ($rose(i_avs_read | i_avs_write)
		|-> o_avs_waitrequest) else $error("no wait on first cycle");
	chk_wait_one: assert property ((i_avs_read | i_avs_write)
		&& o_avs_waitrequest |=> !o_avs_waitrequest)
		else $error("wait longer than one cycle");
	chk_read_upper: assert property (take && i_avs_read
		|-> o_avs_readdata[31:8] == 24'h000000) else $error("upper lanes");
	chk_cfg_unused: assert property (take && i_avs_read && idx == TAI_IDX_CFG
		|-> o_avs_readdata[7:5] == 3'h0 && o_avs_readdata[1:0] == 2'h0)
		else $error("config unused bits set");
	// Interrupt only follows an alarm change, leaves only on access
	chk_irq_cause: assert property ($fell(o_irq_out_n)
		|-> $past(alm) != $past(alm, 2)) else $error("irq without change");
	chk_irq_release: assert property ($rose(o_irq_out_n)
		|-> $past(take && (idx == TAI_IDX_STAT || idx == TAI_IDX_IEN)))
		else $error("irq released without access");
	chk_rst_quiet: assert property (disable iff (1'b0) !i_rst_n
		|-> o_irq_out_n && alm == 3'h0) else $error("active in reset");
	// Cycle two before the last sampled one of an AIS window must be out of frame
	chk_ais_oof: assert property ($rose(o_ais_state)
		|-> $past(!i_in_frame, 3)) else $error("ais while in frame");
	cover property ($fell(o_irq_out_n));
	cover property ($fell(o_red_state));
	cover property (take && idx == TAI_IDX_STAT);
endmodule
`default_nettype wire

// ===== tb/tai_framer_model.sv
`timescale 1ns/1ps
`default_nettype none
module tai_framer_model
(
	// Clock and reset
	input  wire logic       i_clk_sys,
	input  wire logic       i_rst_n,
	// Scenario controls
	input  wire logic       i_oof,
	input  wire logic       i_yel_on,
	input  wire logic [3:0] i_yel_per,
	// Framer indications
	output logic            o_in_frame,
	output logic            o_pcm_valid,
	output logic            o_pcm_bit,
	output logic            o_bit2_valid,
	output logic            o_bit2,
	output logic            o_ybit_valid,
	output logic            o_ybit,
	output logic            o_yel_code_ok
);
	logic [3:0] cnt_q;
	// Code spacing counter; period sets codes per window
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			cnt_q <= 4'h0;
		else
			cnt_q <= (cnt_q >= i_yel_per) ? 4'h0 : cnt_q + 4'h1;
	end
	// Yellow sent as zeros on bit 2 and Y-bit, strobes every cycle
	assign o_yel_code_ok = i_yel_on && cnt_q == 4'h0;
	assign o_in_frame    = !i_oof;
	assign o_pcm_valid   = 1'b1;
	assign o_pcm_bit     = cnt_q[0]; // Changing pattern, never stale
	assign o_bit2_valid  = 1'b1;
	assign o_bit2        = !i_yel_on;
	assign o_ybit_valid  = 1'b1;
	assign o_ybit        = !i_yel_on;
endmodule
`default_nettype wire

// ===== tb/test_t1_alarm_integrator_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_t1_alarm_integrator_regs;
	logic        clk, rst_n, rd, wr, oof, yel_on;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata;
	logic [3:0]  ben, yel_per;
	logic        wreq, irq_n, yellow_state, red, ais, inf, pv, pb, b2v, b2, yv, yb, yok;
	logic [7:0]  exp_q[$];
	int          mismatches, num_checks, seed, n, i;
	// Short windows: one cycle stands for one millisecond
	tai_alarm_integrator #(.P_WIN_RED_CYC(40), .P_WIN_AIS_CYC(60))
	u_tai_alarm_integrator (.i_clk_sys(clk), .i_rst_n(rst_n),
		.i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
		.i_avs_writedata(wdata), .i_avs_byteenable(ben),
		.o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
		.i_in_frame(inf), .i_pcm_valid(pv), .i_pcm_bit(pb),
		.i_bit2_valid(b2v), .i_bit2(b2), .i_ybit_valid(yv), .i_ybit(yb),
		.i_yel_code_ok(yok), .o_yellow_state(yellow_state), .o_red_state(red),
		.o_ais_state(ais), .o_irq_out_n(irq_n));
	tai_framer_model u_tai_framer_model (.i_clk_sys(clk), .i_rst_n(rst_n),
		.i_oof(oof), .i_yel_on(yel_on), .i_yel_per(yel_per),
		.o_in_frame(inf), .o_pcm_valid(pv), .o_pcm_bit(pb),
		.o_bit2_valid(b2v), .o_bit2(b2), .o_ybit_valid(yv), .o_ybit(yb),
		.o_yel_code_ok(yok));
	always #2 clk = ~clk;
	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	// Held until waitrequest low; for reads d is the expected byte
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
		input logic b);
		int k;
		k = 0;
		@(posedge clk);
		addr <= a;
		wr <= w;
		rd <= !w;
		wdata <= {24'($random(seed)), d};
		ben <= {3'($random(seed)), b};
		if (!w)
			exp_q.push_back(d);
		@(posedge clk);
		while (wreq !== 1'b0 && k < 50)
		begin
			@(posedge clk);
			k++;
		end
		if (k >= 50)
			chk("waitrequest", 8'h00, 8'h01);
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Read data taken at the accepting edge only
	always @(posedge clk)
		if (rd && wreq === 1'b0 && exp_q.size() > 0)
			chk("readdata", exp_q.pop_front(), rdata[7:0]);
	// Watchdog well above the expected run of under two thousand cycles
	initial
	begin
		repeat (20000) @(posedge clk);
		mismatches++;
		final_report();
	end
	initial
	begin
		{clk, rst_n, rd, wr, oof, yel_on, addr, wdata, ben} = '0;
		yel_per = 4'h8;
		seed = 15107;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		bus(0, 8'hB0, 8'h00, 1);
		bus(0, 8'hB4, 8'h00, 1);
		bus(0, 8'hB8, 8'h00, 1);
		bus(0, 8'h00, 8'h00, 1);
		// Every legal mode code, reserved one left out
		for (i = 0; i < 7; i++)
		begin
			bus(1, 8'hB0, 8'(i << 2), 1);
			bus(0, 8'hB0, 8'(i << 2), 1);
		end
		bus(1, 8'hB0, 8'h10, 0);
		bus(0, 8'hB0, 8'h18, 1);
		// Four or five codes per window: enough at 2k, short at 4k
		bus(1, 8'hB4, 8'h03, 1);
		yel_on <= 1'b1;
		repeat (100) @(posedge clk);
		chk("yellow_2k", 8'h01, {7'h00, yellow_state});
		chk("irq_masked", 8'h01, {7'h00, irq_n});
		bus(1, 8'hB0, 8'h10, 1);
		repeat (100) @(posedge clk);
		chk("yellow_4k", 8'h00, {7'h00, yellow_state});
		bus(0, 8'hB8, 8'h00, 1);
		yel_on <= 1'b0;
		oof <= 1'b1;
		repeat (200) @(posedge clk);
		chk("irq_set", 8'h00, {7'h00, irq_n});
		bus(0, 8'hB8, 8'h1B, 1);
		repeat (2) @(posedge clk);
		chk("irq_clear", 8'h01, {7'h00, irq_n});
		bus(0, 8'hB8, 8'h03, 1);
		oof <= 1'b0;
		repeat (130) @(posedge clk);
		chk("red_slow", 8'h01, {7'h00, red});
		for (n = 0; (red | ais) !== 1'b0 && n < 600; n++) @(posedge clk);
		bus(0, 8'hB8, 8'h18, 1);
		oof <= 1'b1;
		repeat (200) @(posedge clk);
		bus(0, 8'hB8, 8'h1B, 1);
		bus(1, 8'hB4, 8'h13, 1);
		@(posedge clk);
		oof <= 1'b0;
		for (n = 0; red !== 1'b0 && n < 300; n++) @(posedge clk);
		chk("red_fast", 8'h01, {7'h00, n <= 120});
		for (; ais !== 1'b0 && n < 300; n++) @(posedge clk);
		chk("ais_fast", 8'h01, {7'h00, n <= 180});
		bus(0, 8'hB8, 8'h18, 1);
		final_report();
	end
endmodule
bind tai_alarm_integrator tai_monitor u_tai_monitor (.i_clk_sys(i_clk_sys),
	.i_rst_n(i_rst_n), .i_avs_address(i_avs_address),
	.i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
	.o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
	.i_in_frame(i_in_frame), .o_yellow_state(o_yellow_state),
	.o_red_state(o_red_state), .o_ais_state(o_ais_state),
	.o_irq_out_n(o_irq_out_n));
`default_nettype wire
